// ==== logic/trs_sequencer.sv ====
// transfer roller press/retract sequencer with voltage setting
// and cleaning routines; assumes a 40 MHz clock, pin sensor input
// Overview of operation
// (R1) clutch pulse turns cam half, presses roller
// (R2) sensor blocked means roller pressed
// (R3) next clutch pulse retracts roller
// (R4) sensor unblocked means roller retracted
// (R5) press for transfer and for cleaning
// (R6) retract while detection pattern written
// (R7) retract when media runs out
// (R8) retract after last image of job
// (R9) transfer voltage only once roller pressed
// (R10) setting triggers: print, stabilize, temp, unit
// (R11) setting triggers at page threshold 1000-2000
// (R12) first environment excursion triggers setting once; the code re-arms at every setting end, so a held excursion triggers again
// (R13) setting: press, constant current, measure, store
// (R14) cleaning applies no other voltage
// (R15) cleaning follows belt cleaning in recovery
// (R16) cleaning every 100 pages
// (R17) cleaning on media size error
// (R18) cleaning: press, reverse rev, forward rev
// (R19) five bias pairs then retract
// (R20) clutch off fixed time after sensor edge
// (R21) sensor timeout drops clutch, flags fault
`timescale 1ns/1ps
`include "trs_consts.svh"
module trs_sequencer #(
    parameter logic [31:0] TIMEOUT_CYC = `TRS_TIMEOUT_DEF,
    parameter logic [31:0] REV_CYC     = `TRS_REV_DEF
) (
    // clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             rst_b_i,
    // engine controller
    input  wire trs_pkg::trs_req_t req_i,
    input  wire logic [15:0]      atvs_pages_i,
    input  wire logic [11:0]      surf_volt_i,
    input  wire logic [11:0]      temp_i,
    input  wire logic             fault_clr_i,
    // mechanism pins
    input  wire logic             cam_sensor_i,
    output logic                  clutch_o,
    output trs_pkg::trs_hv_t      hv_mode_o,
    output logic [11:0]           hv_level_o,
    output logic [11:0]           temp_saved_o,
    output logic                  pressed_o,
    output logic                  busy_o,
    output logic                  fault_o
);
    import trs_pkg::*;

    // ----------------------------------------------------------------
    // sensor synchroniser
    // ----------------------------------------------------------------
    logic sens_m, sens;
    // two flops: sensor is a mechanical pin, asynchronous to clk
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sens_m <= 1'b0;
            sens   <= 1'b0;
        end else begin
            sens_m <= cam_sensor_i;
            sens   <= sens_m;
        end
    end

    // ----------------------------------------------------------------
    // state and counters
    // ----------------------------------------------------------------
    trs_state_t state;
    logic [31:0] tmr;
    logic        tgt_press;    // position being moved to
    logic [2:0]  pairs;
    logic [15:0] pg_clean, pg_set;
    logic        env_armed, set_pend, cl_pend, rec_pend;

    // clamp the software threshold into the allowed page window
    function automatic logic [15:0] clamp_pages(input logic [15:0] p);
        if (p < `TRS_ATVS_PAGES_MIN)
            return `TRS_ATVS_PAGES_MIN;
        if (p > `TRS_ATVS_PAGES_MAX)
            return `TRS_ATVS_PAGES_MAX;
        return p;
    endfunction : clamp_pages

    // conversion of measured surface voltage to output level
    function automatic logic [11:0] conv_volt(input logic [11:0] v);
        return v + {1'b0, v[11:1]} > 13'h0FFF ? 12'hFFF
               : 12'(v + {1'b0, v[11:1]});
    endfunction : conv_volt

    // end-of-routine strobes, needed first by the trigger terms below
    wire in_clean = (state == TRS_CL_REV) | (state == TRS_CL_FWD);
    wire set_fin  = (state == TRS_SET_MEAS) && (tmr == REV_CYC);
    wire cl_fin   = (state == TRS_CL_FWD) && (tmr == REV_CYC)
                  && (pairs == `TRS_CLEAN_PAIRS - 3'd1);
    wire [15:0] set_thr = clamp_pages(atvs_pages_i);
    wire sens_ok  = (sens == tgt_press);                  // [R2] [R4]
    wire want_press = req_i.transfer_on & ~req_i.pattern_on; // [R5] [R6]
    wire want_ret = req_i.pattern_on | req_i.media_empty
                  | req_i.last_done;                  // [R6] [R7] [R8]
    // environment: trigger on first excursion only, re-armed by a run
    wire env_trig = req_i.env_exc & env_armed;                 // [R12]
    // page terms are masked in the finishing cycle: the count is still
    // over its limit there and would otherwise queue a second run
    wire set_trig = req_i.print_req | req_i.stab_run | req_i.temp_exc
                  | req_i.unit_new | env_trig
                  | ((pg_set >= set_thr) & ~set_fin);  // [R10] [R11]
    wire cl_trig  = ((pg_clean >= `TRS_CLEAN_PAGES) & ~cl_fin)
                  | req_i.size_err;                        // [R16] [R17]

    // ----------------------------------------------------------------
    // pending routines and page counters
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            set_pend  <= 1'b0;
            cl_pend   <= 1'b0;
            rec_pend  <= 1'b0;
            env_armed <= 1'b1;
            pg_clean  <= 16'h0000;
            pg_set    <= 16'h0000;
        end else begin
            // a new trigger in the finishing cycle wins over the clear
            set_pend <= set_trig | (set_pend & ~set_fin);
            // a size error in the cycle of the belt pulse re-arms the wait
            if (req_i.belt_clean_done)
                rec_pend <= 1'b0;
            if (req_i.size_err)
                rec_pend <= 1'b1;
            // recovery cleaning waits for the belt cleaning pulse [R15]
            cl_pend  <= cl_trig | (rec_pend & req_i.belt_clean_done)
                      | (cl_pend & ~cl_fin);
            if (env_trig)
                env_armed <= 1'b0;
            else if (set_fin)
                env_armed <= 1'b1;
            if (cl_fin)
                pg_clean <= {15'h0000, req_i.page_done};
            else if (req_i.page_done && pg_clean != 16'hFFFF)
                pg_clean <= pg_clean + 16'h0001;
            if (set_fin)
                pg_set <= {15'h0000, req_i.page_done};
            else if (req_i.page_done && pg_set != 16'hFFFF)
                pg_set <= pg_set + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // sequencer: one clutch pulse moves the cam half a turn
    // ----------------------------------------------------------------
    logic       need_press, need_ret;
    assign need_press = (set_pend | cl_pend | want_press) & ~pressed_o;
    assign need_ret   = pressed_o & ~set_pend & ~cl_pend
                      & (want_ret | ~want_press);
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state     <= TRS_IDLE;
            tmr       <= 32'h0000_0000;
            tgt_press <= 1'b0;
            pairs     <= 3'd0;
            clutch_o  <= 1'b0;
            pressed_o <= 1'b0;
            fault_o   <= 1'b0;
            temp_saved_o <= 12'h000;
            hv_level_o   <= 12'h000;
        end else begin
            unique case (state)
            TRS_IDLE: begin
                tmr <= 32'h0000_0000;
                if (need_press || need_ret) begin
                    clutch_o  <= 1'b1;                    // [R1] [R3]
                    tgt_press <= need_press;
                    state     <= TRS_MOVE;
                end else if (pressed_o && cl_pend) begin
                    pairs <= 3'd0;
                    state <= TRS_CL_REV;                       // [R18]
                end else if (pressed_o && set_pend) begin
                    state <= TRS_SET_MEAS;                     // [R13]
                end
            end
            TRS_MOVE: begin
                tmr <= tmr + 32'h0000_0001;
                if (sens_ok) begin
                    tmr   <= 32'h0000_0000;
                    state <= TRS_HOLD;
                end else if (tmr >= TIMEOUT_CYC) begin
                    clutch_o <= 1'b0;                          // [R21]
                    fault_o  <= 1'b1;
                    state    <= TRS_FAULT;
                end
            end
            TRS_HOLD: begin
                // keep driving so the cam clears the sensor edge
                tmr <= tmr + 32'h0000_0001;
                if (tmr == 32'(`TRS_HOLD_CYC) - 32'h0000_0001) begin
                    clutch_o  <= 1'b0;                         // [R20]
                    pressed_o <= tgt_press;               // [R2] [R4]
                    state     <= TRS_IDLE;
                end
            end
            TRS_SET_MEAS: begin
                tmr <= tmr + 32'h0000_0001;
                if (set_fin) begin
                    hv_level_o   <= conv_volt(surf_volt_i);    // [R13]
                    temp_saved_o <= temp_i;
                    state        <= TRS_IDLE;
                end
            end
            TRS_CL_REV: begin
                tmr <= tmr + 32'h0000_0001;
                if (tmr == REV_CYC) begin
                    tmr   <= 32'h0000_0000;
                    state <= TRS_CL_FWD;                       // [R18]
                end
            end
            TRS_CL_FWD: begin
                tmr <= tmr + 32'h0000_0001;
                if (tmr == REV_CYC) begin
                    tmr   <= 32'h0000_0000;
                    pairs <= pairs + 3'd1;
                    // after the fifth pair idle retracts unless needed
                    state <= cl_fin ? TRS_IDLE : TRS_CL_REV;   // [R19]
                end
            end
            TRS_FAULT: begin
                if (fault_clr_i) begin
                    fault_o <= 1'b0;
                    state   <= TRS_IDLE;
                end
            end
            default: state <= TRS_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // high voltage selection
    // ----------------------------------------------------------------
    trs_hv_t next_hv;
    always_comb begin
        next_hv = TRS_HV_OFF;
        if (state == TRS_CL_REV)
            next_hv = TRS_HV_REV;                         // [R14] [R18]
        else if (state == TRS_CL_FWD)
            next_hv = TRS_HV_FWD;
        else if (state == TRS_SET_MEAS)
            next_hv = TRS_HV_CC;                               // [R13]
        else if (state == TRS_IDLE && pressed_o && want_press
                 && !set_pend && !cl_pend)
            next_hv = TRS_HV_FWD;                              // [R9]
    end
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hv_mode_o <= TRS_HV_OFF;
            busy_o    <= 1'b0;
        end else begin
            hv_mode_o <= next_hv;
            busy_o    <= (state != TRS_IDLE);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_hv_needs_press: assert property (@(posedge clk_sys_i)  // [R9]
        disable iff (!rst_b_i)
        hv_mode_o != TRS_HV_OFF |-> $past(pressed_o))
        else $error("voltage applied while roller not pressed");
    a_clean_no_cc: assert property (@(posedge clk_sys_i)  // [R14]
        disable iff (!rst_b_i)
        $past(in_clean) |-> hv_mode_o != TRS_HV_CC)
        else $error("other voltage during cleaning");
    a_timeout_fault: assert property (@(posedge clk_sys_i)  // [R21]
        disable iff (!rst_b_i)
        state == TRS_MOVE && !sens_ok && tmr >= TIMEOUT_CYC
        |=> fault_o && !clutch_o)
        else $error("timeout did not raise fault");
    a_hold_release: assert property (@(posedge clk_sys_i)  // [R20]
        disable iff (!rst_b_i)
        state == TRS_MOVE && sens_ok |=> state == TRS_HOLD && clutch_o)
        else $error("clutch not held after sensor edge");
    a_move_clutch: assert property (@(posedge clk_sys_i)  // [R1]
        disable iff (!rst_b_i)
        $rose(state == TRS_MOVE) |-> clutch_o)
        else $error("move without clutch");
    a_pos_matches: assert property (@(posedge clk_sys_i)  // [R2]
        disable iff (!rst_b_i)
        $fell(state == TRS_HOLD) |-> pressed_o == $past(sens))
        else $error("position flag disagrees with sensor");
    a_pairs_five: assert property (@(posedge clk_sys_i)  // [R19]
        disable iff (!rst_b_i)
        in_clean |-> pairs < `TRS_CLEAN_PAIRS)
        else $error("too many bias pairs");
    a_clean_pressed: assert property (@(posedge clk_sys_i)  // [R5]
        disable iff (!rst_b_i)
        in_clean |-> pressed_o)
        else $error("cleaning while retracted");
    a_pattern_retract: assert property (@(posedge clk_sys_i)  // [R6]
        disable iff (!rst_b_i)
        state == TRS_IDLE && pressed_o && req_i.pattern_on
        && !set_pend && !cl_pend |=> state == TRS_MOVE && clutch_o)
        else $error("roller not retracted for detection pattern");
    a_pairs_done: assert property (@(posedge clk_sys_i)  // [R19]
        disable iff (!rst_b_i)
        cl_fin |=> state == TRS_IDLE && pairs == `TRS_CLEAN_PAIRS)
        else $error("cleaning did not end after five pairs");
endmodule : trs_sequencer

// ==== shared/trs_consts.svh ====
// timing and count constants for the transfer roller sequencer
// assumes a 40 MHz system clock
`ifndef TRS_CONSTS_SVH
`define TRS_CONSTS_SVH
// ----------------------------------------------------------------
// clock and times
// ----------------------------------------------------------------
`define TRS_CLK_MHZ        40
`define TRS_HOLD_US        20
`define TRS_HOLD_CYC       (`TRS_HOLD_US * `TRS_CLK_MHZ)
// ----------------------------------------------------------------
// counts
// ----------------------------------------------------------------
`define TRS_CLEAN_PAGES    16'd100
`define TRS_ATVS_PAGES_DEF 16'd1500
`define TRS_ATVS_PAGES_MIN 16'd1000
`define TRS_ATVS_PAGES_MAX 16'd2000
`define TRS_CLEAN_PAIRS    3'd5
`define TRS_TIMEOUT_DEF    32'd400000
`define TRS_REV_DEF        32'd40000
`endif

// ==== shared/trs_pkg.sv ====
// types for the transfer roller sequencer
// assumes trs_consts.svh for numeric values
package trs_pkg;
    // ----------------------------------------------------------------
    // requests from the engine controller (level or pulse per field)
    // ----------------------------------------------------------------
    typedef struct packed {
        logic print_req;     // pulse: print request accepted
        logic transfer_on;   // level: image transfer in progress
        logic pattern_on;    // level: detection pattern being written
        logic media_empty;   // pulse: media ran out mid-print
        logic last_done;     // pulse: last image transferred
        logic page_done;     // pulse: one page printed
        logic stab_run;      // pulse: image stabilization executed
        logic temp_exc;      // pulse: temperature excursion
        logic env_exc;       // level: temp/humidity out of range
        logic unit_new;      // pulse: roller unit replaced
        logic belt_clean_done; // pulse: belt cleaned in recovery
        logic size_err;      // pulse: media size error
    } trs_req_t;
    typedef enum logic [1:0] {
        TRS_HV_OFF, TRS_HV_FWD, TRS_HV_REV, TRS_HV_CC
    } trs_hv_t;
    typedef enum logic [3:0] {
        TRS_IDLE, TRS_MOVE, TRS_HOLD, TRS_SET_MEAS, TRS_CL_REV,
        TRS_CL_FWD, TRS_FAULT
    } trs_state_t;
endpackage : trs_pkg

// ==== tb/trs_cam_model.sv ====
// cam, lever and position sensor model behind the roller clutch
// assumes the clutch is a registered level from the sequencer
`timescale 1ns/1ps
module trs_cam_model #(
    parameter int MOVE_CYC = 30
) (
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_b_i,
    // mechanism
    input  wire logic clutch_i,
    input  wire logic stall_i,
    output logic      cam_sensor_o
);
    // ----------------------------------------------------------------
    // cam position
    // ----------------------------------------------------------------
    logic     pos;
    logic     moved;
    int       cnt;
    // one half turn per energization; a stalled cam never arrives,
    // which is the only wrong answer a scenario asks for
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pos   <= 1'b0;
            moved <= 1'b0;
            cnt   <= 0;
        end else if (!clutch_i) begin
            moved <= 1'b0;
            cnt   <= 0;
        end else if (!moved && !stall_i) begin
            cnt <= cnt + 1;
            if (cnt == MOVE_CYC) begin
                pos   <= ~pos;
                moved <= 1'b1;
            end
        end
    end
    // blocked (1) while pressed, unblocked while retracted
    assign cam_sensor_o = pos;
endmodule : trs_cam_model

// ==== tb/tb.sv ====
// self-checking bench for the transfer roller sequencer
// assumes trs_pkg compiled first and the cam model beside it
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
    import trs_pkg::*;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic        clk_sys_i = 1'b0;
    logic        rst_b_i   = 1'b0;
    trs_req_t    req       = '0;
    logic [11:0] surf_volt = 12'h200;
    logic [11:0] temp      = 12'h0A5;
    logic        fault_clr = 1'b0;
    logic        stall     = 1'b0;
    logic        sensor;
    logic        clutch;
    trs_hv_t     hv_mode;
    logic [11:0] hv_level;
    logic [11:0] temp_saved;
    logic        pressed;
    logic        busy;
    logic        fault;
    int          errors     = 0;
    int          num_checks = 0;
    int          cyc        = 0;
    // ----------------------------------------------------------------
    // clock, timeout, design and mechanism
    // ----------------------------------------------------------------
    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    // whole run needs about 10k cycles; the ceiling leaves margin
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            final_report();
        end
    end
    trs_sequencer #(.TIMEOUT_CYC(32'd200), .REV_CYC(32'd20)) dut (
        .clk_sys_i    (clk_sys_i),
        .rst_b_i      (rst_b_i),
        .req_i        (req),
        .atvs_pages_i (16'd1000),
        .surf_volt_i  (surf_volt),
        .temp_i       (temp),
        .fault_clr_i  (fault_clr),
        .cam_sensor_i (sensor),
        .clutch_o     (clutch),
        .hv_mode_o    (hv_mode),
        .hv_level_o   (hv_level),
        .temp_saved_o (temp_saved),
        .pressed_o    (pressed),
        .busy_o       (busy),
        .fault_o      (fault)
    );
    trs_cam_model cam (
        .clk_sys_i    (clk_sys_i),
        .rst_b_i      (rst_b_i),
        .clutch_i     (clutch),
        .stall_i      (stall),
        .cam_sensor_o (sensor)
    );
    // forward bias on a retracted roller is never acceptable
    always @(negedge clk_sys_i) begin
        if (rst_b_i && hv_mode === TRS_HV_FWD) `CHK(pressed, 1'b1)
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // bounded wait at falling edges for one of a few conditions
    task automatic wait_until(input int what, input int lim);
        logic hit;
        for (int i = 0; i < lim; i++) begin
            @(negedge clk_sys_i);
            case (what)
                0: hit = (clutch === 1'b1);
                1: hit = (pressed === 1'b1);
                2: hit = (pressed === 1'b0);
                3: hit = (busy === 1'b0);
                4: hit = (fault === 1'b1);
                default: hit = (hv_mode === TRS_HV_CC);
            endcase
            if (hit) return;
        end
    endtask : wait_until
    task automatic final_report();
        $display("checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_print();
        req.print_req   = 1'b1;
        req.transfer_on = 1'b1;
        @(negedge clk_sys_i);
        req.print_req = 1'b0;
        wait_until(0, 50);
        `CHK(clutch, 1'b1)
        wait_until(1, 1500);
        `CHK({pressed, sensor, clutch}, 3'b110)
        wait_until(5, 200);
        `CHK(hv_mode, TRS_HV_CC)
        wait_until(3, 300);
        `CHK(hv_level, 12'h300)
        `CHK(temp_saved, 12'h0A5)
        req.transfer_on = 1'b0;
        req.last_done   = 1'b1;
        @(negedge clk_sys_i);
        req.last_done = 1'b0;
        wait_until(2, 1500);
        `CHK({pressed, sensor}, 2'b00)
        wait_until(3, 1500);
        $display("test print done");
    endtask : test_print
    task automatic test_clean();
        int      revs = 0;
        int      fwds = 0;
        int      rev_cyc = 0;
        int      lowp = 0;
        int      cc = 0;
        trs_hv_t prev = TRS_HV_OFF;
        req.size_err = 1'b1;
        @(negedge clk_sys_i);
        req.size_err = 1'b0;
        for (int i = 0; i < 4000; i++) begin
            @(negedge clk_sys_i);
            if (hv_mode === TRS_HV_REV) begin
                rev_cyc++;
                if (prev !== TRS_HV_REV) revs++;
                if (pressed !== 1'b1) lowp++;
            end
            if (hv_mode === TRS_HV_FWD && prev === TRS_HV_REV) fwds++;
            if (hv_mode === TRS_HV_CC) cc++;
            prev = hv_mode;
            // busy dips for a cycle between moves, so wait for the retract
            if (revs > 0 && pressed === 1'b0) break;
        end
        `CHK(lowp, 0)
        `CHK(cc, 0)
        `CHK(revs, 5)
        `CHK(fwds, 5)
        `CHK(rev_cyc, 5 * 21)
        `CHK(pressed, 1'b0)
        $display("test clean done");
    endtask : test_clean
    task automatic test_recovery();
        // the size error of the cleaning test left the recovery wait armed
        req.belt_clean_done = 1'b1;
        @(negedge clk_sys_i);
        req.belt_clean_done = 1'b0;
        wait_until(1, 1500);
        repeat (2) @(negedge clk_sys_i);
        `CHK(hv_mode, TRS_HV_REV)
        wait_until(2, 1500);
        wait_until(3, 50);
        `CHK({pressed, busy}, 2'b00)
        $display("test recovery done");
    endtask : test_recovery
    task automatic test_pages();
        // 99 pages leave the roller alone, the hundredth starts a clean
        for (int i = 0; i < 100; i++) begin
            `CHK(clutch, 1'b0)
            req.page_done = 1'b1;
            @(negedge clk_sys_i);
            req.page_done = 1'b0;
            @(negedge clk_sys_i);
        end
        wait_until(1, 1500);
        repeat (2) @(negedge clk_sys_i);
        `CHK(hv_mode, TRS_HV_REV)
        wait_until(2, 1500);
        wait_until(3, 50);
        `CHK({pressed, fault}, 2'b00)
        $display("test pages done");
    endtask : test_pages
    task automatic test_pattern();
        req.transfer_on = 1'b1;
        wait_until(1, 1500);
        repeat (2) @(negedge clk_sys_i);
        `CHK(hv_mode, TRS_HV_FWD)
        req.pattern_on = 1'b1;
        wait_until(2, 1500);
        `CHK({pressed, sensor, hv_mode}, 4'h0)
        req.pattern_on  = 1'b0;
        req.transfer_on = 1'b0;
        wait_until(3, 50);
        $display("test pattern done");
    endtask : test_pattern
    task automatic test_fault();
        stall        = 1'b1;
        req.unit_new = 1'b1;
        @(negedge clk_sys_i);
        req.unit_new = 1'b0;
        wait_until(4, 400);
        `CHK({fault, clutch}, 2'b10)
        stall     = 1'b0;
        fault_clr = 1'b1;
        @(negedge clk_sys_i);
        fault_clr = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        `CHK(fault, 1'b0)
        // the setting left pending by the unit swap resumes after the clear
        wait_until(5, 1500);
        `CHK(hv_mode, TRS_HV_CC)
        $display("test fault done");
    endtask : test_fault
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(negedge clk_sys_i);
        `CHK({clutch, hv_mode, pressed, busy, fault}, 6'h00)
        rst_b_i = 1'b1;
        @(negedge clk_sys_i);
        test_print();
        test_clean();
        test_recovery();
        test_pages();
        test_pattern();
        test_fault();
        final_report();
    end
endmodule : tb
